// ==== reset_source_control.sv ====
`timescale 1ns/1ps
`include "reset_source_regs.svh"

// Overview of operation
// - threshold register accepts four codes selecting 2.1, 2.55, 3.15 or 3.8 volts
// - any other threshold code resets core 2-3 slow ticks later, register to default
// - a real low-supply reset starts 2-3 slow ticks later, threshold code kept
// - supply reset sets control bit 2; only a software zero write clears it
// - bad threshold code sets control bit 1; only a software zero write clears it
// - control bits 6 to 3 read as zero
// - watchdog expiry while running acts as pin reset and sets time-out flag
// - watchdog expiry while halted clears only counter, stack and watchdog, sets time-out and power-down
// - wake start-up lasts 15-16 fast, 1024 crystal or 1-2 slow clocks
// - bad watchdog key resets the core and sets the watchdog fault flag
// - key 10101 disables the watchdog, 01010 enables it and is the default
// - time-out and power-down flags follow the reset kind and run mode
// - any reset zeroes counter, masks interrupts, restarts watchdog, idles timer, ports
// - supply reset only when low supply lasts beyond the qualifying time
// - supply monitoring is off while powered down
module reset_source_control #(
	parameter int SUPPLY_QUAL_CYCLES = (`SUPPLY_QUAL_NS * `CLK_MHZ + 999) / 1000
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic [3:0] addr,
	input wire logic [7:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [7:0] readData,
	input wire logic lowSpeedOsc,
	input wire logic supplyLow,
	input wire logic extResetPin_n,
	input wire logic usbReset,
	input wire logic watchdogExpired,
	input wire logic sleepMode,
	input wire logic idleMode,
	input wire logic [1:0] clockSource,
	output logic coreReset,
	output logic pcStackClear,
	output logic watchdogRestart,
	output logic startupBusy,
	output logic [7:0] thresholdCode,
	output logic supplyMonitorEn,
	output logic watchdogEnable,
	output logic [2:0] watchdogPeriodSelect,
	output logic idleSysclkKeep,
	output logic timeoutFlag,
	output logic powerDownFlag,
	output logic irq
);

	localparam int QW = $clog2(SUPPLY_QUAL_CYCLES + 1);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic codeValid(input logic [7:0] code);
		codeValid = (code == `THR_CODE_2V10) || (code == `THR_CODE_2V55) ||
			(code == `THR_CODE_3V15) || (code == `THR_CODE_3V80);
	endfunction : codeValid

	function automatic logic keyValid(input logic [4:0] key);
		keyValid = (key == `WDT_KEY_DISABLE) || (key == `WDT_KEY_ENABLE);
	endfunction : keyValid

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] pinRaw;
	logic [3:0] pinLevel;
	logic [3:0] pinRise;

	assign pinRaw = {usbReset, ~extResetPin_n, supplyLow, lowSpeedOsc};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			pin_sync #(
				.RESET_LEVEL(1'b0)
			) u_sync (
				.ref_clk(ref_clk),
				.arst_n(arst_n),
				.clkEn(clkEn),
				.pinIn(pinRaw[gi]),
				.level(pinLevel[gi]),
				.rise(pinRise[gi])
			);
		end
	endgenerate

	logic lsTick;
	logic supplyLowSync;
	logic pinResetActive;

	assign lsTick = pinRise[0];
	assign supplyLowSync = pinLevel[1];
	assign pinResetActive = pinLevel[2] | pinLevel[3];

	// ----------------------------------------
	// state
	// ----------------------------------------
	reset_source_pkg::seq_state_e state;
	reset_source_pkg::seq_state_e next_state;
	logic [QW-1:0] lowCount;
	logic [QW-1:0] next_lowCount;
	logic supplyQualified;
	logic next_supplyQualified;
	logic [2:0] pending;
	logic [2:0] next_pending;
	logic [7:0] thrReg;
	logic [7:0] next_thrReg;
	logic [7:0] wdtReg;
	logic [7:0] next_wdtReg;
	logic sysclkKeep;
	logic next_sysclkKeep;
	logic [2:0] cause;
	logic [2:0] next_cause;
	logic next_timeoutFlag;
	logic next_powerDownFlag;
	logic [`IRQ_WIDTH-1:0] irqStatus;
	logic [`IRQ_WIDTH-1:0] next_irqStatus;
	logic [`IRQ_WIDTH-1:0] irqEnable;
	logic [`IRQ_WIDTH-1:0] next_irqEnable;
	logic [`IRQ_WIDTH-1:0] irqSet;
	logic [7:0] next_readData;
	logic next_pcStackClear;
	logic next_watchdogRestart;
	logic cntStart;
	logic cntTick;
	logic [10:0] cntLimit;
	logic cntDone;
	logic halted;
	logic wrThr;
	logic wrCause;
	logic wrWdt;
	logic wrIrqClr;
	logic wrIrqEn;

	assign halted = sleepMode | idleMode;

	// ----------------------------------------
	// supply qualification
	// ----------------------------------------
	// short dips restart the count; power-down stops monitoring entirely
	always_comb
	begin
		next_lowCount = lowCount;
		next_supplyQualified = supplyQualified;
		if (!supplyLowSync || sleepMode)
		begin
			next_lowCount = '0;
			next_supplyQualified = 1'b0;
		end
		else if (lowCount < QW'(SUPPLY_QUAL_CYCLES))
			next_lowCount = lowCount + {{(QW-1){1'b0}}, 1'b1};
		else
			next_supplyQualified = 1'b1;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lowCount <= '0;
			supplyQualified <= 1'b0;
			supplyMonitorEn <= 1'b1;
		end
		else if (clkEn)
		begin
			lowCount <= next_lowCount;
			supplyQualified <= next_supplyQualified;
			supplyMonitorEn <= ~sleepMode;
		end
	end

	// ----------------------------------------
	// delay counter, slow ticks or start-up clocks
	// ----------------------------------------
	tick_counter #(
		.WIDTH(11)
	) u_delay (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.start(cntStart),
		.tick(cntTick),
		.limit(cntLimit),
		.done(cntDone)
	);

	// start-up length follows the running clock source
	always_comb
	begin
		cntTick = lsTick;
		cntLimit = `LS_DELAY_TICKS;
		if (state == reset_source_pkg::ST_STARTUP)
		begin
			if (clockSource == reset_source_pkg::SRC_LOW_SPEED_INTERNAL_OSC)
				cntLimit = `SST_LOW_SPEED_INTERNAL_OSC_TICKS;
			else
			begin
				cntTick = 1'b1;
				// registered done adds one clock, so stop the count one short
				cntLimit = ((clockSource == reset_source_pkg::SRC_HXT) ?
					`SST_HXT_CYCLES : `SST_HIGH_SPEED_INTERNAL_OSC_CYCLES) - 11'h001;
			end
		end
	end

	// ----------------------------------------
	// reset sequencer and registers
	// ----------------------------------------
	assign wrThr = writeStrobe && (addr == `ADDR_THRESHOLD);
	assign wrCause = writeStrobe && (addr == `ADDR_CAUSE);
	assign wrWdt = writeStrobe && (addr == `ADDR_WATCHDOG);
	assign wrIrqClr = writeStrobe && (addr == `ADDR_IRQ_CLEAR);
	assign wrIrqEn = writeStrobe && (addr == `ADDR_IRQ_ENABLE);

	// checks look only at slow ticks, so a glitchy write yields one clean reset
	always_comb
	begin
		next_state = state;
		next_pending = pending;
		next_thrReg = wrThr ? writeData : thrReg;
		next_wdtReg = wrWdt ? writeData : wdtReg;
		next_sysclkKeep = wrCause ? writeData[`CAUSE_SYSCLK_KEEP_BIT] : sysclkKeep;
		next_timeoutFlag = timeoutFlag;
		next_powerDownFlag = powerDownFlag;
		next_pcStackClear = 1'b0;
		next_watchdogRestart = 1'b0;
		cntStart = 1'b0;
		irqSet = '0;
		case (state)
			reset_source_pkg::ST_IDLE:
			begin
				if (pinResetActive)
				begin
					next_state = reset_source_pkg::ST_RESET;
					irqSet[`IRQ_PIN_BIT] = 1'b1;
				end
				else if (watchdogExpired && halted)
				begin
					next_pcStackClear = 1'b1;
					next_watchdogRestart = 1'b1;
					next_timeoutFlag = 1'b1;
					next_powerDownFlag = 1'b1;
					irqSet[`IRQ_TIMEOUT_BIT] = 1'b1;
					cntStart = 1'b1;
					next_state = reset_source_pkg::ST_STARTUP;
				end
				else if (watchdogExpired)
				begin
					next_timeoutFlag = 1'b1;
					irqSet[`IRQ_TIMEOUT_BIT] = 1'b1;
					next_state = reset_source_pkg::ST_RESET;
				end
				else if (lsTick && (!codeValid(thrReg) || supplyQualified ||
					!keyValid(wdtReg[`WDT_KEY_MSB:`WDT_KEY_LSB])))
				begin
					next_pending = {supplyQualified, !codeValid(thrReg),
						!keyValid(wdtReg[`WDT_KEY_MSB:`WDT_KEY_LSB])};
					cntStart = 1'b1;
					next_state = reset_source_pkg::ST_DELAY;
				end
			end
			reset_source_pkg::ST_DELAY:
			begin
				if (pinResetActive)
					next_state = reset_source_pkg::ST_RESET;
				else if (cntDone)
				begin
					if (pending[1])
					begin
						next_thrReg = `THR_POR;
						irqSet[`IRQ_THR_FAULT_BIT] = 1'b1;
					end
					irqSet[`IRQ_SUPPLY_BIT] = pending[2];
					irqSet[`IRQ_WDT_FAULT_BIT] = pending[0];
					next_state = reset_source_pkg::ST_RESET;
				end
			end
			reset_source_pkg::ST_RESET:
			begin
				// supply reset keeps the threshold code; key returns to default
				next_wdtReg = `WDT_POR;
				next_watchdogRestart = 1'b1;
				if (!pinResetActive && !supplyQualified && lsTick)
				begin
					next_pending = '0;
					next_state = reset_source_pkg::ST_IDLE;
				end
			end
			reset_source_pkg::ST_STARTUP:
			begin
				if (pinResetActive)
					next_state = reset_source_pkg::ST_RESET;
				else if (cntDone)
					next_state = reset_source_pkg::ST_IDLE;
			end
			default:
				next_state = reset_source_pkg::ST_IDLE;
		endcase
		// watchdog held cleared from the very first cycle of a core reset
		if (next_state == reset_source_pkg::ST_RESET)
			next_watchdogRestart = 1'b1;
	end

	// ----------------------------------------
	// sticky flags and interrupts
	// ----------------------------------------
	// hardware set wins over a zero write landing in the same cycle
	always_comb
	begin
		next_cause = cause;
		if (wrCause)
			next_cause = cause & writeData[2:0];
		if (state == reset_source_pkg::ST_DELAY && cntDone)
		begin
			next_cause[`CAUSE_SUPPLY_BIT] = next_cause[`CAUSE_SUPPLY_BIT] | pending[2];
			next_cause[`CAUSE_THR_FAULT_BIT] = next_cause[`CAUSE_THR_FAULT_BIT] |
				pending[1];
			next_cause[`CAUSE_WDT_FAULT_BIT] = next_cause[`CAUSE_WDT_FAULT_BIT] |
				pending[0];
		end
		next_irqStatus = (irqStatus & ~(wrIrqClr ? writeData[`IRQ_WIDTH-1:0] : '0)) | irqSet;
		next_irqEnable = wrIrqEn ? writeData[`IRQ_WIDTH-1:0] : irqEnable;
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb
	begin
		next_readData = 8'h00;
		if (readStrobe)
		begin
			if (addr == `ADDR_THRESHOLD)
				next_readData = thrReg;
			else if (addr == `ADDR_CAUSE)
				next_readData = {sysclkKeep, 4'h0, cause};
			else if (addr == `ADDR_WATCHDOG)
				next_readData = wdtReg;
			else if (addr == `ADDR_FLAGS)
				next_readData = {5'h00, startupBusy, timeoutFlag, powerDownFlag};
			else if (addr == `ADDR_IRQ_STATUS)
				next_readData = {3'h0, irqStatus};
			else if (addr == `ADDR_IRQ_ENABLE)
				next_readData = {3'h0, irqEnable};
			else
				next_readData = 8'h00;
		end
	end

	// power-on clears both reset flags; watchdog expiry sets time-out (power-down too when halted), other resets leave them alone
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= reset_source_pkg::ST_IDLE;
			pending <= 3'h0;
			thrReg <= `THR_POR;
			wdtReg <= `WDT_POR;
			sysclkKeep <= 1'b0;
			cause <= 3'h0;
			timeoutFlag <= 1'b0;
			powerDownFlag <= 1'b0;
			irqStatus <= '0;
			irqEnable <= '0;
			irq <= 1'b0;
			readData <= 8'h00;
			coreReset <= 1'b0;
			pcStackClear <= 1'b0;
			watchdogRestart <= 1'b0;
			startupBusy <= 1'b0;
			thresholdCode <= `THR_POR;
			watchdogEnable <= 1'b1;
			watchdogPeriodSelect <= 3'h3;
			idleSysclkKeep <= 1'b0;
		end
		else if (clkEn)
		begin
			state <= next_state;
			pending <= next_pending;
			thrReg <= next_thrReg;
			wdtReg <= next_wdtReg;
			sysclkKeep <= next_sysclkKeep;
			cause <= next_cause;
			timeoutFlag <= next_timeoutFlag;
			powerDownFlag <= next_powerDownFlag;
			irqStatus <= next_irqStatus;
			irqEnable <= next_irqEnable;
			irq <= |(next_irqStatus & next_irqEnable);
			readData <= next_readData;
			coreReset <= (next_state == reset_source_pkg::ST_RESET);
			pcStackClear <= next_pcStackClear;
			watchdogRestart <= next_watchdogRestart;
			startupBusy <= (next_state == reset_source_pkg::ST_STARTUP);
			thresholdCode <= next_thrReg;
			watchdogEnable <= (next_wdtReg[`WDT_KEY_MSB:`WDT_KEY_LSB] == `WDT_KEY_ENABLE);
			watchdogPeriodSelect <= next_wdtReg[2:0];
			idleSysclkKeep <= next_sysclkKeep;
		end
	end

endmodule : reset_source_control

// ==== reset_source_regs.svh ====
`ifndef RESET_SOURCE_REGS_SVH
`define RESET_SOURCE_REGS_SVH

// ----------------------------------------
// register offsets on the plain port
// ----------------------------------------
`define ADDR_THRESHOLD 4'h0
`define ADDR_CAUSE 4'h1
`define ADDR_WATCHDOG 4'h2
`define ADDR_FLAGS 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_CLEAR 4'h5
`define ADDR_IRQ_ENABLE 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define CAUSE_SYSCLK_KEEP_BIT 7
`define CAUSE_SUPPLY_BIT 2
`define CAUSE_THR_FAULT_BIT 1
`define CAUSE_WDT_FAULT_BIT 0
`define WDT_KEY_MSB 7
`define WDT_KEY_LSB 3
`define FLAGS_TIMEOUT_BIT 1
`define FLAGS_POWER_DOWN_BIT 0
`define FLAGS_BUSY_BIT 2
`define IRQ_SUPPLY_BIT 0
`define IRQ_THR_FAULT_BIT 1
`define IRQ_WDT_FAULT_BIT 2
`define IRQ_TIMEOUT_BIT 3
`define IRQ_PIN_BIT 4
`define IRQ_WIDTH 5

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define THR_CODE_2V10 8'h55
`define THR_CODE_2V55 8'h33
`define THR_CODE_3V15 8'h99
`define THR_CODE_3V80 8'hAA
`define THR_POR 8'h55
`define WDT_POR 8'h53
`define WDT_KEY_DISABLE 5'h15
`define WDT_KEY_ENABLE 5'h0A

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 125
`define SUPPLY_QUAL_NS 100000
`define LS_DELAY_TICKS 11'h002
`define SST_HIGH_SPEED_INTERNAL_OSC_CYCLES 11'h010
`define SST_HXT_CYCLES 11'h400
`define SST_LOW_SPEED_INTERNAL_OSC_TICKS 11'h002

`endif

// ==== reset_source_pkg.sv ====
package reset_source_pkg;

	// sequencer states
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_DELAY,
		ST_RESET,
		ST_STARTUP
	} seq_state_e;

	// system clock source, steers the wake start-up delay
	typedef enum logic [1:0]
	{
		SRC_HIGH_SPEED_INTERNAL_OSC,
		SRC_HXT,
		SRC_LOW_SPEED_INTERNAL_OSC
	} clk_src_e;

endpackage : reset_source_pkg

// ==== pin_sync.sv ====
`timescale 1ns/1ps

module pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic pinIn,
	output logic level,
	output logic rise
);

	logic stage1;
	logic stage2;
	logic stage3;
	logic next_level;
	logic next_rise;

	// a change counts only once the second and third stages agree
	always_comb
	begin
		next_level = level;
		next_rise = 1'b0;
		if (stage2 == stage3)
		begin
			next_level = stage3;
			next_rise = stage3 & ~level;
		end
	end

	// stage1 feeds stage2 only, nothing else looks at it
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1 <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			stage3 <= RESET_LEVEL;
			level <= RESET_LEVEL;
			rise <= 1'b0;
		end
		else if (clkEn)
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
			rise <= next_rise;
		end
	end

endmodule : pin_sync

// ==== tick_counter.sv ====
`timescale 1ns/1ps

module tick_counter #(
	parameter int WIDTH = 11
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic start,
	input wire logic tick,
	input wire logic [WIDTH-1:0] limit,
	output logic done
);

	logic [WIDTH-1:0] count;
	logic running;
	logic [WIDTH-1:0] next_count;
	logic next_running;
	logic next_done;

	// counts ticks after start; done pulses one clock after the limit-th tick
	always_comb
	begin
		next_count = count;
		next_running = running;
		next_done = 1'b0;
		if (start)
		begin
			next_count = '0;
			next_running = 1'b1;
		end
		else if (running && tick)
		begin
			next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
			if (next_count >= limit)
			begin
				next_running = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= '0;
			running <= 1'b0;
			done <= 1'b0;
		end
		else if (clkEn)
		begin
			count <= next_count;
			running <= next_running;
			done <= next_done;
		end
	end

endmodule : tick_counter

// ==== reset_source_control_chk.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// port checker
// ----------------------------------------
module reset_source_control_chk #(
	parameter int SUPPLY_QUAL_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic readStrobe,
	input wire logic [7:0] readData,
	input wire logic extResetPin_n,
	input wire logic watchdogExpired,
	input wire logic sleepMode,
	input wire logic idleMode,
	input wire logic [1:0] clockSource,
	input wire logic coreReset,
	input wire logic pcStackClear,
	input wire logic watchdogRestart,
	input wire logic startupBusy,
	input wire logic supplyMonitorEn,
	input wire logic timeoutFlag,
	input wire logic powerDownFlag
);
	logic [10:0] busyCnt;
	logic [10:0] next_busyCnt;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// length of the current wake start-up, frozen with the block
	always_comb
	begin
		next_busyCnt = busyCnt;
		if (clkEn)
			next_busyCnt = startupBusy ? busyCnt + 11'h001 : 11'h000;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			busyCnt <= 11'h000;
		else
			busyCnt <= next_busyCnt;
	end

	// read data must stand only in the cycle after a read
	a_read_idle_zero: assert property ($past(clkEn) && !$past(readStrobe) |-> readData == 8'h00)
		else $error("read data not zero");
	a_wdt_run_reset: assert property (clkEn && watchdogExpired && !sleepMode && !idleMode
		&& !coreReset && !startupBusy |=> coreReset && timeoutFlag)
		else $error("running expiry gave no reset");
	a_wdt_halt_wake: assert property (clkEn && watchdogExpired && (sleepMode || idleMode)
		&& !coreReset && !startupBusy |=> pcStackClear && timeoutFlag && powerDownFlag)
		else $error("halted expiry gave no wake");
	a_clear_pulse: assert property (pcStackClear |=> !pcStackClear)
		else $error("counter clear too long");
	a_clear_restart: assert property (pcStackClear |-> watchdogRestart && !coreReset)
		else $error("bad wake reset");
	a_core_restart: assert property (coreReset |-> watchdogRestart)
		else $error("watchdog not restarted");
	a_busy_rc: assert property ($fell(startupBusy) && clockSource == 2'h0
		|-> busyCnt inside {[11'h00F:11'h010]})
		else $error("bad fast start-up length");
	a_busy_xtal: assert property ($fell(startupBusy) && clockSource == 2'h1
		|-> busyCnt inside {[11'h400:11'h401]})
		else $error("bad crystal start-up length");
	a_busy_slow: assert property ($fell(startupBusy) && clockSource == 2'h2
		|-> busyCnt inside {[11'h010:11'h024]})
		else $error("bad slow start-up length");
	a_monitor_off: assert property (sleepMode && $past(sleepMode) && $past(sleepMode, 2)
		|-> !supplyMonitorEn)
		else $error("monitor on in power-down");
	a_pin_reset: assert property ((clkEn && !extResetPin_n) [*6] |-> coreReset)
		else $error("pin gave no reset");
endmodule : reset_source_control_chk

bind reset_source_control reset_source_control_chk #(.SUPPLY_QUAL_CYCLES(SUPPLY_QUAL_CYCLES))
	i_reset_source_control_chk (.ref_clk, .arst_n, .clkEn, .readStrobe, .readData,
	.extResetPin_n, .watchdogExpired, .sleepMode, .idleMode, .clockSource, .coreReset,
	.pcStackClear, .watchdogRestart, .startupBusy, .supplyMonitorEn, .timeoutFlag,
	.powerDownFlag);

// ==== tb_top.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// self-checking bench
// ----------------------------------------
module tb_top;
	logic ref_clk = 1'b0;
	logic lowSpeedOsc = 1'b0;
	logic arst_n, clkEn, writeStrobe, readStrobe, supplyLow, extResetPin_n, usbReset;
	logic watchdogExpired, sleepMode, idleMode, coreReset, pcStackClear, watchdogRestart;
	logic startupBusy, supplyMonitorEn, watchdogEnable, idleSysclkKeep, timeoutFlag;
	logic powerDownFlag, irq;
	logic [1:0] clockSource;
	logic [2:0] watchdogPeriodSelect;
	logic [3:0] addr;
	logic [7:0] writeData, readData, thresholdCode, code;
	logic [7:0] validTab [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 10086;
	int n;

	reset_source_control #(.SUPPLY_QUAL_CYCLES(8)) i_reset_source_control (
		.ref_clk, .arst_n, .clkEn, .addr, .writeData, .writeStrobe, .readStrobe, .readData,
		.lowSpeedOsc, .supplyLow, .extResetPin_n, .usbReset, .watchdogExpired, .sleepMode,
		.idleMode, .clockSource, .coreReset, .pcStackClear, .watchdogRestart, .startupBusy,
		.thresholdCode, .supplyMonitorEn, .watchdogEnable, .watchdogPeriodSelect,
		.idleSysclkKeep, .timeoutFlag, .powerDownFlag, .irq);

	// slow oscillator is 17 fast periods, edges away from the fast rising edge
	always #4 ref_clk = ~ref_clk;
	initial
	begin
		#2;
		forever #68 lowSpeedOsc = ~lowSpeedOsc;
	end

	// a hang counts as a mismatch
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	task automatic test_done();
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
		n_compared++;
		if (got !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, e, got);
		end
	endtask : chk

	// bus tasks start at a rising edge and return at the falling edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge ref_clk);
		writeStrobe <= 1'b0;
		@(negedge ref_clk);
	endtask : wr

	task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string what);
		@(posedge ref_clk);
		addr <= a;
		readStrobe <= 1'b1;
		@(posedge ref_clk);
		readStrobe <= 1'b0;
		@(negedge ref_clk);
		chk(what, e, readData);
	endtask : rdchk

	task automatic pulse();
		@(posedge ref_clk);
		watchdogExpired <= 1'b1;
		@(posedge ref_clk);
		watchdogExpired <= 1'b0;
		@(negedge ref_clk);
	endtask : pulse

	task automatic waitRise(input int lim, output int k);
		k = 0;
		while (coreReset !== 1'b1 && k < lim)
		begin
			@(negedge ref_clk);
			k++;
		end
	endtask : waitRise

	task automatic waitFree();
		int k;
		k = 0;
		while ((coreReset !== 1'b0 || startupBusy !== 1'b0) && k < 300)
		begin
			@(negedge ref_clk);
			k++;
		end
		chk("coreReset", 8'h00, {7'h00, coreReset});
	endtask : waitFree

	// accepted wake start-up length per clock source
	function automatic logic sstOk(input logic [1:0] s, input int k);
		case (s)
			2'h0: return k >= 15 && k <= 16;
			2'h1: return k >= 1024 && k <= 1025;
			default: return k >= 16 && k <= 36;
		endcase
	endfunction : sstOk

	initial
	begin
		arst_n <= 1'b0;
		clkEn <= 1'b1;
		addr <= 4'h0;
		writeData <= 8'h00;
		writeStrobe <= 1'b0;
		readStrobe <= 1'b0;
		supplyLow <= 1'b0;
		extResetPin_n <= 1'b1;
		usbReset <= 1'b0;
		watchdogExpired <= 1'b0;
		sleepMode <= 1'b0;
		idleMode <= 1'b0;
		clockSource <= 2'h0;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		chk("thresholdCode", 8'h55, thresholdCode);
		rdchk(4'h2, 8'h53, "watchdog");
		chk("watchdogEnable", 8'h01, {7'h00, watchdogEnable});
		rdchk(4'hF, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h0, validTab[i]);
			rdchk(4'h0, validTab[i], "threshold");
			waitRise(70, n);
			chk("noReset", 8'h46, n[7:0]);
		end
		// corner code zero, then random undefined codes
		for (int i = 0; i < 3; i++)
		begin
			code = (i == 0) ? 8'h00 : 8'($random(seed));
			if (code inside {8'h55, 8'h33, 8'h99, 8'hAA})
				code ^= 8'h01;
			wr(4'h0, code);
			waitRise(80, n);
			chk("delayOk", 8'h01, {7'h00, n >= 32 && n <= 60});
			chk("thresholdCode", 8'h55, thresholdCode);
			waitFree();
			rdchk(4'h0, 8'h55, "threshold");
			wr(4'h1, 8'hFF);
			rdchk(4'h1, 8'h82, "cause");
			chk("keep", 8'h01, {7'h00, idleSysclkKeep});
			wr(4'h1, 8'h00);
			rdchk(4'h1, 8'h00, "cause");
		end
		// interrupt raised, masked and cleared
		wr(4'h6, 8'h02);
		rdchk(4'h4, 8'h02, "irqStatus");
		chk("irq", 8'h01, {7'h00, irq});
		wr(4'h6, 8'h00);
		rdchk(4'h6, 8'h00, "irqEnable");
		chk("irq", 8'h00, {7'h00, irq});
		wr(4'h5, 8'h1F);
		wr(4'h6, 8'h02);
		rdchk(4'h4, 8'h00, "irqStatus");
		chk("irq", 8'h00, {7'h00, irq});
		// both defined keys, then bad keys
		wr(4'h2, 8'hAB);
		rdchk(4'h2, 8'hAB, "watchdog");
		chk("watchdogEnable", 8'h00, {7'h00, watchdogEnable});
		chk("period", 8'h03, {5'h00, watchdogPeriodSelect});
		wr(4'h2, 8'h55);
		rdchk(4'h2, 8'h55, "watchdog");
		chk("watchdogEnable", 8'h01, {7'h00, watchdogEnable});
		for (int i = 0; i < 3; i++)
		begin
			code = (i == 0) ? 8'hFF : 8'($random(seed));
			if (code[7:3] == 5'h15 || code[7:3] == 5'h0A)
				code[7] = ~code[7];
			wr(4'h2, code);
			waitRise(80, n);
			chk("keyReset", 8'h01, {7'h00, coreReset});
			waitFree();
			rdchk(4'h1, 8'h01, "cause");
			rdchk(4'h2, 8'h53, "watchdog");
			wr(4'h1, 8'h00);
		end
		// short dip, power-down, then a qualified low supply
		wr(4'h0, 8'h99);
		@(posedge ref_clk);
		supplyLow <= 1'b1;
		repeat (4) @(posedge ref_clk);
		supplyLow <= 1'b0;
		waitRise(80, n);
		chk("noReset", 8'h50, n[7:0]);
		@(posedge ref_clk);
		sleepMode <= 1'b1;
		supplyLow <= 1'b1;
		waitRise(80, n);
		chk("noReset", 8'h50, n[7:0]);
		chk("monitor", 8'h00, {7'h00, supplyMonitorEn});
		@(posedge ref_clk);
		sleepMode <= 1'b0;
		waitRise(120, n);
		chk("supplyReset", 8'h01, {7'h00, coreReset});
		chk("thresholdCode", 8'h99, thresholdCode);
		@(posedge ref_clk);
		supplyLow <= 1'b0;
		waitFree();
		rdchk(4'h1, 8'h04, "cause");
		wr(4'h1, 8'h00);
		rdchk(4'h1, 8'h00, "cause");
		// expiry while running, then while halted from each clock source
		pulse();
		chk("timeoutFlag", 8'h01, {7'h00, timeoutFlag});
		chk("powerDownFlag", 8'h00, {7'h00, powerDownFlag});
		waitFree();
		rdchk(4'h3, 8'h02, "flags");
		for (int s = 0; s < 3; s++)
		begin
			@(posedge ref_clk);
			clockSource <= s[1:0];
			idleMode <= (s != 2);
			sleepMode <= (s == 2);
			pulse();
			chk("pcStackClear", 8'h01, {7'h00, pcStackClear});
			chk("coreReset", 8'h00, {7'h00, coreReset});
			n = 0;
			repeat (1100)
			begin
				n += int'(startupBusy === 1'b1);
				@(negedge ref_clk);
			end
			chk("startupOk", 8'h01, {7'h00, sstOk(s[1:0], n)});
			chk("flags", 8'h03, {6'h00, timeoutFlag, powerDownFlag});
			chk("thresholdCode", 8'h99, thresholdCode);
			@(posedge ref_clk);
			idleMode <= 1'b0;
			sleepMode <= 1'b0;
		end
		// pin and usb resets leave both flags alone
		for (int p = 0; p < 2; p++)
		begin
			@(posedge ref_clk);
			extResetPin_n <= (p != 0);
			usbReset <= (p == 1);
			waitRise(12, n);
			chk("pinReset", 8'h01, {7'h00, coreReset});
			chk("flags", 8'h03, {6'h00, timeoutFlag, powerDownFlag});
			@(posedge ref_clk);
			extResetPin_n <= 1'b1;
			usbReset <= 1'b0;
			waitFree();
		end
		// power-on reset in mid-run clears both flags
		@(posedge ref_clk);
		arst_n <= 1'b0;
		@(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		chk("flags", 8'h00, {6'h00, timeoutFlag, powerDownFlag});
		test_done();
	end
endmodule : tb_top
